// ### logic/cdec_core.sv
// Opcode decode, length/cycle sequencing and flag update for the CPU subset.
// Assumes the memory side presents the operand byte with the opcode.
// Functional notes
// - A5 ANDs A with operand, updates N,Z only; 2 bytes, 2 cycles.
// - Jump loads EA, no flags; BC2 CC3 FC2 EC3 DC4 cycles.
// - Call pushes return, no flags; BD5 CD6 FD5 ED5 DD6 cycles.
// - RMW forms A,X,direct,indexed,indexed8; increment 3C..7C updates N,Z.
// - Test updates N,Z, no write; 4,4,5 cycles in memory forms.
// - Logical shift right: zero into bit7, bit0 to carry, N=0, Z updated.
// - Rotate left through carry; updates N,Z; 39..79.
// - Relative branches 2 bytes, 3 cycles, no flags; 20 always, 21 never.
// - 22..27 branch on C|Z, C, Z as encoded.
// - 28..2D branch on H, N, I as encoded.
// - 2E branches on interrupt pin low, 2F on high, pin sampled.
// - AD relative call, 2 bytes, 5 cycles, saves return, no flags.
// - Bit test-and-branch 3 bytes, 5 cycles; tested bit into carry.
// - Bit set/clear 2 bytes, 5 cycles, no flags.
// - 97 copies A to X, 9F X to A; 2 cycles, no flags.
// - 99 sets carry, 98 clears it; one cycle each.
// - 9B sets mask, 9A clears it; 2 cycles each.
// - 83 software interrupt, 10 cycles, sets mask.
// - 80 reloads flags from stack in 8 cycles; 81 returns in 5.
// - 9C sets stack pointer to FF in 2 cycles; 9D idles 1 cycle.
// - 8D decimal adjust, 2 cycles, N,Z updated, carry set not cleared.
// - 8F enters wait mode, 8E stop mode; 4 cycles each.
// - Unassigned opcodes are undefined; flagged, no state change.
module cdec_core (
    input  wire logic                mclk,
    input  wire logic                rst_n,
    input  wire logic                issue_valid,
    input  wire logic [7:0]          opcode,
    input  wire logic [7:0]          operand,
    input  wire cdec_pkg::cdec_cc_s  stack_cc,
    input  wire logic                irq_pin,
    input  wire logic                wake,
    output logic                     ready,
    output logic                     done,
    output cdec_pkg::cdec_res_s      result,
    output logic [7:0]               acc,
    output logic [7:0]               idx,
    output logic [7:0]               sp,
    output cdec_pkg::cdec_cc_s       cc,
    output logic                     wait_mode,
    output logic                     stop_mode
);
    import cdec_pkg::*;

    logic [7:0] acc_q, acc_d, idx_q, idx_d, sp_q, sp_d;
    cdec_cc_s   cc_q, cc_d;
    cdec_res_s  res_q, res_d;
    logic       done_q, wait_q, stop_q, wait_d, stop_d;
    logic [3:0] cnt_q;
    logic [2:0] pin_sync_q;
    logic       pin_q;
    logic       take;
    logic [7:0] src, rmw;
    logic [8:0] sum;
    logic       bit_sel;
    logic       cond;
    logic [3:0] lo, hi;
    logic       rmw_mem;

    assign take      = issue_valid && ready;
    assign ready     = (cnt_q == 4'h0) && !wait_q && !stop_q;
    assign done      = done_q;
    assign result    = res_q;
    assign acc       = acc_q;
    assign idx       = idx_q;
    assign sp        = sp_q;
    assign cc        = cc_q;
    assign wait_mode = wait_q;
    assign stop_mode = stop_q;
    assign lo        = opcode[3:0];
    assign hi        = opcode[7:4];
    assign bit_sel   = operand[opcode[3:1]];
    assign rmw_mem   = (hi == 4'h3) || (hi == 4'h6) || (hi == 4'h7);

    // ----------------------------------------
    // Interrupt pin filter
    // ----------------------------------------
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            pin_sync_q <= 3'h0;
        end else begin
            pin_sync_q <= {pin_sync_q[1:0], irq_pin};
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            pin_q <= 1'b0;
        end else if (pin_sync_q[1] == pin_sync_q[2]) begin
            pin_q <= pin_sync_q[2];
        end
    end

    // ----------------------------------------
    // Branch condition
    // ----------------------------------------
    always_comb begin
        unique case (lo[3:1])
            3'h0: cond = 1'b1;
            3'h1: cond = !(cc_q.c || cc_q.z);
            3'h2: cond = !cc_q.c;
            3'h3: cond = !cc_q.z;
            3'h4: cond = !cc_q.h;
            3'h5: cond = !cc_q.n;
            3'h6: cond = !cc_q.i;
            3'h7: cond = !pin_q;
        endcase
        if (lo[0]) begin
            cond = !cond;
        end
    end

    // ----------------------------------------
    // Decode and execute
    // ----------------------------------------
    always_comb begin
        acc_d  = acc_q;
        idx_d  = idx_q;
        sp_d   = sp_q;
        cc_d   = cc_q;
        wait_d = 1'b0;
        stop_d = 1'b0;
        res_d  = '{len: 2'h1, cycles: CYC_1, wr_en: 1'b0, wr_data: 8'h00, branch: 1'b0, unsupported: 1'b1};
        src    = (hi == 4'h4) ? acc_q : ((hi == 4'h5) ? idx_q : operand);
        rmw    = src;
        sum    = {1'b0, acc_q} + {1'b0, operand};
        if (hi == 4'h0) begin
            res_d = '{len: 2'h3, cycles: CYC_5, wr_en: 1'b0, wr_data: 8'h00,
                      branch: (bit_sel == !opcode[0]), unsupported: 1'b0};
            cc_d.c = bit_sel;
        end else if (hi == 4'h1) begin
            rmw = operand;
            rmw[opcode[3:1]] = !opcode[0];
            res_d = '{len: 2'h2, cycles: CYC_5, wr_en: 1'b1, wr_data: rmw, branch: 1'b0, unsupported: 1'b0};
        end else if (hi == 4'h2) begin
            res_d = '{len: 2'h2, cycles: CYC_3, wr_en: 1'b0, wr_data: 8'h00, branch: cond, unsupported: 1'b0};
        end else if ((hi >= 4'h3) && (hi <= 4'h7)
                     && (lo == LO_INC || lo == LO_CLR || lo == LO_TST || lo == LO_LSR || lo == LO_ROL)) begin
            res_d.unsupported = 1'b0;
            res_d.len    = (hi == 4'h3 || hi == 4'h6) ? 2'h2 : 2'h1;
            res_d.cycles = (hi == 4'h4 || hi == 4'h5) ? CYC_2
                         : ((hi == 4'h6) ? CYC_6 : CYC_5);
            unique case (lo)
                LO_INC: rmw = src + 8'h01;
                LO_CLR: rmw = 8'h00;
                LO_TST: begin
                    rmw = src - 8'h00;
                    if (rmw_mem) begin
                        res_d.cycles = (hi == 4'h6) ? CYC_5 : CYC_4;
                    end
                end
                LO_LSR: begin
                    rmw    = {1'b0, src[7:1]};
                    cc_d.c = src[0];
                end
                default: begin
                    rmw    = {src[6:0], cc_q.c};
                    cc_d.c = src[7];
                end
            endcase
            cc_d.n = rmw[7];
            cc_d.z = (rmw == 8'h00);
            if (lo != LO_TST) begin
                if (hi == 4'h4) acc_d = rmw;
                else if (hi == 4'h5) idx_d = rmw;
                else res_d.wr_en = 1'b1;
                res_d.wr_data = rmw;
            end
        end else if ((hi >= 4'hB) && (lo == LO_JMP || lo == LO_CALL)) begin
            res_d.unsupported = 1'b0;
            res_d.branch      = 1'b1;
            res_d.len = (hi == 4'hC || hi == 4'hD) ? 2'h3 : ((hi == 4'hF) ? 2'h1 : 2'h2);
            if (lo == LO_JMP) begin
                unique case (hi)
                    4'hB, 4'hF: res_d.cycles = CYC_2;
                    4'hC, 4'hE: res_d.cycles = CYC_3;
                    default:    res_d.cycles = CYC_4;
                endcase
            end else begin
                res_d.cycles = (hi == 4'hC || hi == 4'hD) ? CYC_6 : CYC_5;
                sp_d = sp_q - SP_RET_BYTES;
            end
        end else begin
            res_d.unsupported = 1'b0;
            unique case (opcode)
                OP_BIT_IMM: begin
                    res_d.len = 2'h2; res_d.cycles = CYC_2;
                    cc_d.n = acc_q[7] & operand[7];
                    cc_d.z = ((acc_q & operand) == 8'h00);
                end
                OP_ADD_IMM: begin
                    res_d.len = 2'h2; res_d.cycles = CYC_2;
                    acc_d  = sum[7:0];
                    cc_d.h = sum[4] ^ acc_q[4] ^ operand[4];
                    cc_d.c = sum[8];
                    cc_d.n = sum[7];
                    cc_d.z = (sum[7:0] == 8'h00);
                end
                OP_REL_CALL: begin
                    res_d.len = 2'h2; res_d.cycles = CYC_5; res_d.branch = 1'b1;
                    sp_d = sp_q - SP_RET_BYTES;
                end
                OP_TAX: begin res_d.cycles = CYC_2; idx_d = acc_q; end
                OP_TXA: begin res_d.cycles = CYC_2; acc_d = idx_q; end
                OP_SEC: cc_d.c = 1'b1;
                OP_CLC: cc_d.c = 1'b0;
                OP_SEI: begin res_d.cycles = CYC_2; cc_d.i = 1'b1; end
                OP_CLI: begin res_d.cycles = CYC_2; cc_d.i = 1'b0; end
                OP_SWI: begin
                    res_d.cycles = CYC_10; res_d.branch = 1'b1; cc_d.i = 1'b1;
                    sp_d = sp_q - SP_INT_BYTES;
                end
                OP_RTI: begin
                    res_d.cycles = CYC_8; res_d.branch = 1'b1; cc_d = stack_cc;
                    sp_d = sp_q + SP_INT_BYTES;
                end
                OP_RTS: begin
                    res_d.cycles = CYC_5; res_d.branch = 1'b1;
                    sp_d = sp_q + SP_RET_BYTES;
                end
                OP_RSP: begin res_d.cycles = CYC_2; sp_d = SP_INIT; end
                OP_IDLE: res_d.cycles = CYC_1;
                OP_DAA: begin
                    res_d.cycles = CYC_2;
                    rmw = 8'h00;
                    if (cc_q.h || (acc_q[3:0] > 4'h9)) rmw[3:0] = 4'h6;
                    if (cc_q.c || (acc_q > 8'h99)) begin
                        rmw[7:4] = 4'h6;
                        cc_d.c   = 1'b1;
                    end
                    acc_d  = acc_q + rmw;
                    cc_d.n = acc_d[7];
                    cc_d.z = (acc_d == 8'h00);
                end
                OP_STOP: begin res_d.cycles = CYC_4; stop_d = 1'b1; end
                OP_WAIT: begin res_d.cycles = CYC_4; wait_d = 1'b1; end
                default: res_d.unsupported = 1'b1;
            endcase
        end
    end

    // ----------------------------------------
    // Architectural state
    // ----------------------------------------
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            acc_q <= RST_ACC;
            idx_q <= RST_IDX;
            sp_q  <= RST_SP;
            cc_q  <= RST_CC;
        end else if (take && !res_d.unsupported) begin
            acc_q <= acc_d;
            idx_q <= idx_d;
            sp_q  <= sp_d;
            cc_q  <= cc_d;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            res_q  <= '0;
            done_q <= 1'b0;
        end else begin
            done_q <= take;
            if (take) begin
                res_q <= res_d;
            end
        end
    end

    // ----------------------------------------
    // Cycle sequencing and low-power modes
    // ----------------------------------------
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            cnt_q <= 4'h0;
        end else if (take) begin
            cnt_q <= res_d.cycles - 4'h1;
        end else if (cnt_q != 4'h0) begin
            cnt_q <= cnt_q - 4'h1;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            wait_q <= 1'b0;
            stop_q <= 1'b0;
        end else if (wake) begin
            wait_q <= 1'b0;
            stop_q <= 1'b0;
        end else if (take) begin
            wait_q <= wait_d;
            stop_q <= stop_d;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    clear_flags_a: assert property (@(posedge mclk) disable iff (!rst_n)
        take && lo == LO_CLR && hi >= 4'h3 && hi <= 4'h7 |=> cc_q.z && !cc_q.n && cc_q.c == $past(cc_q.c))
        else $error("clear did not force flags");
    branch_always_a: assert property (@(posedge mclk) disable iff (!rst_n)
        take && opcode == OP_BRA |=> res_q.branch && res_q.cycles == CYC_3 ##0 !ready[*2] ##1 ready)
        else $error("branch always wrong");
    branch_never_a: assert property (@(posedge mclk) disable iff (!rst_n)
        take && opcode == OP_BRN |=> !res_q.branch)
        else $error("branch never taken");
    trap_return_a: assert property (@(posedge mclk) disable iff (!rst_n)
        take && opcode == OP_RTI |=> cc_q == $past(stack_cc) ##0 !ready[*7] ##1 ready)
        else $error("return from trap timing or flags wrong");
    carry_set_a: assert property (@(posedge mclk) disable iff (!rst_n)
        take && opcode == OP_SEC |=> cc_q.c && ready)
        else $error("carry set wrong");
    stack_init_a: assert property (@(posedge mclk) disable iff (!rst_n)
        take && opcode == OP_RSP |=> sp_q == SP_INIT ##1 ready)
        else $error("stack pointer not reset");
    swi_mask_a: assert property (@(posedge mclk) disable iff (!rst_n)
        take && opcode == OP_SWI |=> cc_q.i && !ready[*8] ##1 !ready ##1 ready)
        else $error("software interrupt wrong");
    bit_carry_a: assert property (@(posedge mclk) disable iff (!rst_n)
        take && hi == 4'h0 |=> cc_q.c == $past(bit_sel) && res_q.len == 2'h3)
        else $error("tested bit not in carry");
    copy_index_a: assert property (@(posedge mclk) disable iff (!rst_n)
        take && opcode == OP_TAX |=> idx_q == $past(acc_q) && cc_q == $past(cc_q))
        else $error("copy to index wrong");
    low_power_a: assert property (@(posedge mclk) disable iff (!rst_n)
        take && opcode == OP_WAIT && !wake |=> (wait_q && !ready))
        else $error("wait mode not entered");

endmodule // cdec_core

// ### logic/cdec_pkg.sv
// Constants, opcodes and carrier types for the opcode decode and execute subset.
// Assumes a single clock domain and a synchronous active-low reset.
package cdec_pkg;

    // ----------------------------------------
    // Condition codes and result carrier
    // ----------------------------------------
    typedef struct packed {
        logic h;
        logic i;
        logic n;
        logic z;
        logic c;
    } cdec_cc_s;

    typedef struct packed {
        logic [1:0] len;
        logic [3:0] cycles;
        logic       wr_en;
        logic [7:0] wr_data;
        logic       branch;
        logic       unsupported;
    } cdec_res_s;

    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [7:0] RST_ACC = 8'h00;
    localparam logic [7:0] RST_IDX = 8'h00;
    localparam logic [7:0] RST_SP  = 8'hFF;
    localparam cdec_cc_s   RST_CC  = 5'h08;
    localparam logic [7:0] SP_INIT = 8'hFF;

    // ----------------------------------------
    // Opcodes
    // ----------------------------------------
    localparam logic [7:0] OP_BIT_IMM  = 8'hA5;
    localparam logic [7:0] OP_ADD_IMM  = 8'hAB;
    localparam logic [7:0] OP_REL_CALL = 8'hAD;
    localparam logic [7:0] OP_TAX      = 8'h97;
    localparam logic [7:0] OP_TXA      = 8'h9F;
    localparam logic [7:0] OP_CLC      = 8'h98;
    localparam logic [7:0] OP_SEC      = 8'h99;
    localparam logic [7:0] OP_CLI      = 8'h9A;
    localparam logic [7:0] OP_SEI      = 8'h9B;
    localparam logic [7:0] OP_RSP      = 8'h9C;
    localparam logic [7:0] OP_IDLE     = 8'h9D;
    localparam logic [7:0] OP_SWI      = 8'h83;
    localparam logic [7:0] OP_RTI      = 8'h80;
    localparam logic [7:0] OP_RTS      = 8'h81;
    localparam logic [7:0] OP_DAA      = 8'h8D;
    localparam logic [7:0] OP_STOP     = 8'h8E;
    localparam logic [7:0] OP_WAIT     = 8'h8F;
    localparam logic [7:0] OP_BRA      = 8'h20;
    localparam logic [7:0] OP_BRN      = 8'h21;
    localparam logic [3:0] LO_JMP      = 4'hC;
    localparam logic [3:0] LO_CALL     = 4'hD;
    localparam logic [3:0] LO_INC      = 4'hC;
    localparam logic [3:0] LO_CLR      = 4'hF;
    localparam logic [3:0] LO_TST      = 4'hD;
    localparam logic [3:0] LO_LSR      = 4'h4;
    localparam logic [3:0] LO_ROL      = 4'h9;

    // ----------------------------------------
    // Cycle counts
    // ----------------------------------------
    localparam logic [3:0] CYC_1  = 4'h1;
    localparam logic [3:0] CYC_2  = 4'h2;
    localparam logic [3:0] CYC_3  = 4'h3;
    localparam logic [3:0] CYC_4  = 4'h4;
    localparam logic [3:0] CYC_5  = 4'h5;
    localparam logic [3:0] CYC_6  = 4'h6;
    localparam logic [3:0] CYC_8  = 4'h8;
    localparam logic [3:0] CYC_10 = 4'hA;

    // ----------------------------------------
    // Stack adjustments
    // ----------------------------------------
    localparam logic [7:0] SP_RET_BYTES = 8'h02;
    localparam logic [7:0] SP_INT_BYTES = 8'h05;

endpackage

// ### tb/cdec_core_tb_top.sv
// Self-checking bench for the opcode decode core.
// Assumes the far model supplies stack flags and the interrupt pin.
module cdec_core_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import cdec_pkg::*;
    logic       mclk, rst_n, issue_valid, wake, pin_level;
    logic [7:0] opcode, operand, acc, idx, sp;
    logic       irq_pin, ready, done, wait_mode, stop_mode;
    cdec_cc_s   stack_cc, stack_img, cc;
    cdec_res_s  result;
    int         n_errors, n_compared, lowc;
    logic [39:0] rows [$];
    logic [31:0] regs [$];
    localparam logic [7:0] BIT_PAT = 8'h5A;
    // ----------------------------------------
    // Clock, design and far model
    // ----------------------------------------
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    cdec_core uut (.mclk(mclk), .rst_n(rst_n), .issue_valid(issue_valid), .opcode(opcode), .operand(operand),
        .stack_cc(stack_cc), .irq_pin(irq_pin), .wake(wake), .ready(ready), .done(done), .result(result),
        .acc(acc), .idx(idx), .sp(sp), .cc(cc), .wait_mode(wait_mode), .stop_mode(stop_mode));
    cdec_far_model far (.mclk(mclk), .pin_level(pin_level), .stack_img(stack_img), .irq_pin(irq_pin),
        .stack_cc(stack_cc));
    // ----------------------------------------
    // Compare, issue and closing tasks
    // ----------------------------------------
    task automatic close_out();
        $display("Errors %0d, comparisons %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk_v(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_cc(input cdec_cc_s got, input cdec_cc_s exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic issue(input logic [7:0] op, input logic [7:0] opr);
        int k;
        for (k = 0; k < 100 && ready !== 1'b1; k++) @(negedge mclk);
        if (k == 100) begin
            n_errors++;
            close_out();
        end
        @(posedge mclk);
        issue_valid <= 1'b1;
        opcode      <= op;
        operand     <= opr;
        @(posedge mclk);
        issue_valid <= 1'b0;
        @(negedge mclk);
        chk_v({7'h00, done}, 8'h01);
        for (lowc = 0; lowc < 12 && ready !== 1'b1; lowc++) @(negedge mclk);
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        logic [39:0] r;
        logic [31:0] g;
        n_errors = 0;
        n_compared = 0;
        rst_n = 1'b0;
        issue_valid = 1'b0;
        wake = 1'b0;
        pin_level = 1'b1;
        opcode = 8'h00;
        operand = 8'h00;
        stack_img = 5'h15;
        rows = {40'h20_00_23_10_00, 40'h21_00_23_00_00, 40'h22_00_23_10_00, 40'h23_00_23_00_00,
            40'h24_00_23_10_00, 40'h25_00_23_00_00, 40'h26_00_23_10_00, 40'h27_00_23_00_00, 40'h28_00_23_10_00,
            40'h29_00_23_00_00, 40'h2A_00_23_10_00, 40'h2B_00_23_00_00, 40'h2C_00_23_00_00, 40'h2D_00_23_10_00,
            40'h2E_00_23_00_00, 40'h2F_00_23_10_00, 40'h99_00_11_00_00, 40'h25_00_23_10_00, 40'h24_00_23_00_00,
            40'h23_00_23_10_00, 40'h98_00_11_00_00, 40'h24_00_23_10_00, 40'h9A_00_12_00_00, 40'h2C_00_23_10_00,
            40'h9B_00_12_00_00, 40'h2D_00_23_10_00, 40'h3C_7F_25_01_80, 40'h2B_00_23_10_00, 40'h2A_00_23_00_00,
            40'h7C_FF_15_01_00, 40'h27_00_23_10_00, 40'h26_00_23_00_00, 40'h6C_00_26_01_01, 40'h26_00_23_10_00,
            40'h3F_AA_25_01_00, 40'h27_00_23_10_00, 40'h7F_AA_15_01_00, 40'h6F_AA_26_01_00, 40'h3D_80_24_02_00,
            40'h2B_00_23_10_00, 40'h7D_00_14_02_00, 40'h27_00_23_10_00, 40'h6D_01_25_02_00, 40'h34_81_25_01_40,
            40'h25_00_23_10_00, 40'h2A_00_23_10_00, 40'h74_02_15_01_01, 40'h24_00_23_10_00, 40'h64_01_26_01_00,
            40'h27_00_23_10_00, 40'h39_80_25_01_01, 40'h79_00_15_01_01, 40'h69_40_26_01_80, 40'h2B_00_23_10_00,
            40'h24_00_23_10_00, 40'hBC_00_22_10_00, 40'hCC_00_33_10_00, 40'hFC_00_12_10_00, 40'hEC_00_23_10_00,
            40'hDC_00_34_10_00, 40'hBD_00_25_10_00, 40'hCD_00_36_10_00, 40'hFD_00_15_10_00, 40'hED_00_25_10_00,
            40'hDD_00_36_10_00, 40'hAD_00_25_10_00, 40'hA5_FF_22_00_00, 40'h27_00_23_10_00, 40'h9D_00_11_00_00,
            40'h9C_00_12_00_00, 40'h83_00_1A_10_00, 40'h2D_00_23_10_00, 40'h81_00_15_10_00, 40'h80_00_18_10_00,
            40'h2B_00_23_10_00, 40'h25_00_23_10_00, 40'h29_00_23_10_00, 40'h2C_00_23_10_00};
        regs = {32'h4F_00_00_13, 32'hAB_19_19_00, 32'hAB_28_41_10, 32'h8D_00_47_10, 32'hAB_60_A7_04,
            32'h8D_00_07_01, 32'h97_00_07_01, 32'h5C_00_07_01, 32'h9F_00_08_01, 32'h44_00_04_00,
            32'h99_00_04_01, 32'h49_00_09_00, 32'h4C_00_0A_00, 32'h5F_00_0A_02, 32'h9F_00_00_02,
            32'h99_00_00_03, 32'h8D_00_60_01};
        repeat (3) @(posedge mclk);
        rst_n <= 1'b1;
        @(negedge mclk);
        chk_v(acc, RST_ACC);
        chk_v(sp, RST_SP);
        chk_v(idx, RST_IDX);
        chk_cc(cc, 5'h08);
        chk_v({6'h00, ready, done}, 8'h02);
        foreach (rows[j]) begin
            r = rows[j];
            issue(r[39:32], r[31:24]);
            chk_v({6'h00, result.len}, {4'h0, r[23:20]});
            chk_v({4'h0, result.cycles}, {4'h0, r[19:16]});
            chk_v(8'(lowc), {4'h0, r[19:16]} - 8'h01);
            chk_v({6'h00, result.unsupported, result.branch}, {7'h00, r[12]});
            if (r[9:8] != 2'h0) chk_v({7'h00, result.wr_en}, {7'h00, r[8]});
            if (r[9:8] == 2'h1) chk_v(result.wr_data, r[7:0]);
        end
        chk_v(sp, 8'h01);
        foreach (regs[j]) begin
            g = regs[j];
            issue(g[31:24], g[23:16]);
            chk_v(acc, g[15:8]);
            chk_cc(cc, g[4:0]);
        end
        for (int b = 0; b < 8; b++) begin
            issue(8'h10 + 8'(2 * b), BIT_PAT);
            chk_v(result.wr_data, BIT_PAT | (8'h01 << b));
            issue(8'h11 + 8'(2 * b), BIT_PAT);
            chk_v(result.wr_data, BIT_PAT & ~(8'h01 << b));
            issue(8'(2 * b), BIT_PAT);
            chk_v({4'h0, result.len, result.branch, cc.c}, {4'h0, 2'h3, {2{BIT_PAT[b]}}});
            issue(8'h01 + 8'(2 * b), BIT_PAT);
            chk_v({2'h0, result.cycles, result.branch, cc.c}, {2'h0, 4'h5, ~BIT_PAT[b], BIT_PAT[b]});
        end
        @(posedge mclk);
        pin_level <= 1'b0;
        repeat (6) @(posedge mclk);
        issue(8'h2E, 8'h00);
        chk_v({7'h00, result.branch}, 8'h01);
        issue(8'h31, 8'h00);
        chk_v({result.unsupported, acc[6:0]}, 8'hE0);
        for (int m = 0; m < 2; m++) begin
            issue(m ? 8'h8E : 8'h8F, 8'h00);
            chk_v({result.cycles, stop_mode, wait_mode}, {4'h4, m[0], ~m[0]});
            chk_v(8'(lowc), 8'h0C);
            @(posedge mclk);
            wake <= 1'b1;
            @(posedge mclk);
            wake <= 1'b0;
            repeat (2) @(negedge mclk);
            chk_v({stop_mode, wait_mode, ready}, 8'h01);
        end
        @(posedge mclk);
        rst_n <= 1'b0;
        repeat (3) @(posedge mclk);
        rst_n <= 1'b1;
        @(negedge mclk);
        chk_v(acc, RST_ACC);
        chk_v(idx, RST_IDX);
        chk_v(sp, RST_SP);
        chk_cc(cc, RST_CC);
        chk_v({4'h0, stop_mode, wait_mode, ready, done}, 8'h02);
        close_out();
    end
endmodule // cdec_core_tb_top

// ### tb/cdec_far_model.sv
// Far side of the decode core: stack image and external interrupt pin.
// Assumes the bench sets the stack image and pin level between instructions.
module cdec_far_model (
    input  wire logic                mclk,
    input  wire logic                pin_level,
    input  wire cdec_pkg::cdec_cc_s  stack_img,
    output logic                     irq_pin,
    output cdec_pkg::cdec_cc_s       stack_cc
);
    timeunit 1ns;
    timeprecision 100ps;
    import cdec_pkg::*;
    // ----------------------------------------
    // Pin and stack presentation
    // ----------------------------------------
    always_ff @(posedge mclk) begin
        irq_pin  <= pin_level;
        stack_cc <= stack_img;
    end
endmodule // cdec_far_model
